// ### hdl/iqd_pkg.sv
package iqd_pkg;
  localparam int ADC_W      = 14;
  localparam int NCH        = 8;
  localparam int GRP        = 4;
  localparam int NGRP       = 2;
  localparam int SEL_W      = 3;
  localparam int OUT_W      = 16;
  localparam int TAPS_PER_M = 16;
  localparam int BANK_PER_M = 8;
  localparam int COEF_W     = 14;
  localparam int COEF_FRAC  = 13;
  localparam int LO_W       = 16;
  localparam int LO_FRAC    = 14;
  localparam int LUT_BITS   = 4;
  localparam int QTR        = 16;
  localparam int ACC_W      = 40;
  localparam int FIFO_DEPTH = 2;
  localparam int A_W        = 8;
  localparam logic [A_W-1:0] A_CTRL  = 8'h00;
  localparam logic [A_W-1:0] A_DECIM = 8'h04;
  localparam logic [A_W-1:0] A_OFS0  = 8'h08;
  localparam logic [A_W-1:0] A_OFS1  = 8'h0C;
  localparam logic [A_W-1:0] A_FREQ0 = 8'h10;
  localparam logic [A_W-1:0] A_FREQ1 = 8'h14;
  localparam logic [A_W-1:0] A_MUX   = 8'h18;
  localparam logic [A_W-1:0] A_CADDR = 8'h1C;
  localparam logic [A_W-1:0] A_CDATA = 8'h20;
  localparam logic [A_W-1:0] A_STAT  = 8'h24;
  localparam int B_DEMOD_BYP = 0;
  localparam int B_PDN       = 1;
  localparam int B_DC_BYP    = 2;
  localparam int B_MIX_BYP   = 3;
  localparam int B_DEC_BYP   = 4;
  localparam int B_MUX_BYP   = 5;
  localparam int CTRL_W      = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [23:0]       MUX_RST  = 24'hFA_C688;
  localparam logic [COEF_W-1:0] SIN_Q [QTR+1] = '{
    14'h0000, 14'h0646, 14'h0C7C, 14'h1294, 14'h187E, 14'h1E2B, 14'h238E, 14'h2899,
    14'h2D41, 14'h3178, 14'h3536, 14'h3871, 14'h3B20, 14'h3D3E, 14'h3EC5, 14'h3FB0,
    14'h3FFF};
  typedef struct packed {
    logic [NCH-1:0][ADC_W-1:0] smp;
  } iqd_adc_s;
  typedef struct packed {
    logic [OUT_W-1:0] i;
    logic [OUT_W-1:0] q;
  } iqd_lane_s;
  typedef struct packed {
    iqd_lane_s [NCH-1:0] lane;
  } iqd_word_s;
  typedef struct packed {
    logic           cyc;
    logic           stb;
    logic           we;
    logic [A_W-1:0] adr;
    logic [3:0]     sel;
    logic [31:0]    dat;
  } iqd_wb_req_s;
endpackage

// ### hdl/iqd_top.sv
// Functional notes
// - Accept 14-bit samples per channel, one per clock, up to 65 MSPS.
// - Whole demodulator can be bypassed (raw data) or powered down.
// - Down-conversion comes before decimation in every channel path.
// - Two identical groups: channels one to four, and five to eight.
// - DC removal, mixing, decimation and multiplexing each bypass independently.
// - DC removal subtracts a programmed offset from each sample.
// - In-phase is sample times cosine, quadrature is sample times negated sine.
// - Cosine and negated sine carry 14 magnitude bits plus a sign bit.
// - Oscillator frequency steps are the sample rate divided by 2^16.
// - Decimation filter is a symmetric FIR with RAM-loaded coefficients.
// - Filter length is sixteen times the decimation factor.
// - Bank holds 8M coefficients of 14 bits; software loads all of them.
// - Down-sampler keeps one filtered sample in M, drops the rest.
// - Multiplexer after the decimator routes any channel to any lane.
`timescale 1ns/1ps
module iqd_top #(
  parameter int MAX_DECIM = 64
) (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               clk_en,
  input  wire iqd_pkg::iqd_adc_s  adc_in,
  input  wire logic               adc_valid,
  output logic                    adc_ready,
  output logic                    out_valid,
  output iqd_pkg::iqd_word_s      out_word,
  input  wire logic               out_ready,
  input  wire iqd_pkg::iqd_wb_req_s wb_req,
  output logic                    wb_ack,
  output logic [31:0]             wb_dat_r
);
  import iqd_pkg::*;
  localparam int MW   = $clog2(MAX_DECIM + 1);
  localparam int PW   = (MAX_DECIM > 1) ? $clog2(MAX_DECIM) : 1;
  localparam int BANK = BANK_PER_M * MAX_DECIM;
  localparam int CIW  = $clog2(BANK);
  localparam int KW   = $clog2(TAPS_PER_M * MAX_DECIM);

  if (MAX_DECIM < 2 || MAX_DECIM > 64)
  begin : g_bad_decim
    $error("MAX_DECIM must lie between 2 and 64");
  end

  logic [CTRL_W-1:0]             ctrl, next_ctrl;
  logic [MW-1:0]                 decim, next_decim;
  logic [NGRP-1:0][ADC_W-1:0]    ofs, next_ofs;
  logic [NGRP-1:0][LO_W-1:0]     freq, next_freq;
  logic [23:0]                   muxsel, next_muxsel;
  logic [CIW:0]                  caddr, next_caddr;
  logic                          next_ack;
  logic [31:0]                   next_rdat;
  logic                          bus_wr, coef_wr, decim_wr;
  logic signed [COEF_W-1:0]      coef [NGRP][BANK];
  logic                          pdn, byp_all, byp_dec, byp_mux;
  logic                          sp_v;
  logic [PW-1:0]                 ph, next_ph;

  assign pdn     = ctrl[B_PDN];
  assign byp_all = ctrl[B_DEMOD_BYP];
  assign byp_dec = ctrl[B_DEC_BYP] | byp_all;
  assign byp_mux = ctrl[B_MUX_BYP] | byp_all;
  // Writes take effect on the edge where the master sees ack.
  assign bus_wr  = wb_req.cyc & wb_req.stb & wb_req.we & wb_ack;
  assign coef_wr = bus_wr & (wb_req.adr == A_CDATA) & (&wb_req.sel[1:0]);

  function automatic logic [31:0] merge(input logic [31:0] cur, input iqd_wb_req_s r);
    logic [31:0] bm;
    bm = '0;
    for (int b = 0; b < 4; b++)
      bm[8*b +: 8] = {8{r.sel[b]}};
    return (cur & ~bm) | (r.dat & bm);
  endfunction

  logic [31:0] wv;
  always_comb
  begin
    next_ack    = wb_req.cyc & wb_req.stb & ~wb_ack;
    next_rdat   = '0;
    next_ctrl   = ctrl;
    next_decim  = decim;
    next_ofs    = ofs;
    next_freq   = freq;
    next_muxsel = muxsel;
    next_caddr  = caddr;
    decim_wr    = 1'b0;
    wv          = '0;
    unique case (wb_req.adr)
      A_CTRL:  wv = 32'(ctrl);
      A_DECIM: wv = 32'(decim);
      A_OFS0:  wv = 32'(ofs[0]);
      A_OFS1:  wv = 32'(ofs[1]);
      A_FREQ0: wv = 32'(freq[0]);
      A_FREQ1: wv = 32'(freq[1]);
      A_MUX:   wv = 32'(muxsel);
      A_CADDR: wv = 32'(caddr);
      A_CDATA: wv = 32'(coef[caddr[CIW]][caddr[CIW-1:0]]);
      A_STAT:  wv = 32'({2'(out_valid) + 2'(sp_v), 8'(ph), pdn});
      default: wv = '0;
    endcase
    if (next_ack && !wb_req.we)
      next_rdat = (wb_req.adr == A_CDATA) ? (wv & 32'h0000_3FFF) : wv;
    if (bus_wr)
    begin
      unique case (wb_req.adr)
        A_CTRL:  next_ctrl = CTRL_W'(merge(wv, wb_req));
        A_DECIM:
        begin
          if (merge(wv, wb_req) >= 32'h0000_0001 && merge(wv, wb_req) <= 32'(MAX_DECIM))
          begin
            next_decim = MW'(merge(wv, wb_req));
            decim_wr   = 1'b1;
          end
        end
        A_OFS0:  next_ofs[0] = ADC_W'(merge(wv, wb_req));
        A_OFS1:  next_ofs[1] = ADC_W'(merge(wv, wb_req));
        A_FREQ0: next_freq[0] = LO_W'(merge(wv, wb_req));
        A_FREQ1: next_freq[1] = LO_W'(merge(wv, wb_req));
        A_MUX:   next_muxsel = 24'(merge(wv, wb_req));
        A_CADDR: next_caddr = (CIW+1)'(merge(wv, wb_req));
        A_CDATA: next_caddr = coef_wr ? caddr + 1'b1 : caddr;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl     <= CTRL_RST;
      decim    <= MW'(1);
      ofs      <= '0;
      freq     <= '0;
      muxsel   <= MUX_RST;
      caddr    <= '0;
      wb_ack   <= 1'b0;
      wb_dat_r <= '0;
    end
    else if (clk_en)
    begin
      ctrl     <= next_ctrl;
      decim    <= next_decim;
      ofs      <= next_ofs;
      freq     <= next_freq;
      muxsel   <= next_muxsel;
      caddr    <= next_caddr;
      wb_ack   <= next_ack;
      wb_dat_r <= next_rdat;
    end
  end

  // Coefficient RAM, loaded through the auto-incrementing data port.
  always_ff @(posedge clk_sys)
  begin
    if (clk_en && coef_wr)
      coef[caddr[CIW]][caddr[CIW-1:0]] <= wb_req.dat[COEF_W-1:0];
  end

  function automatic logic signed [LO_FRAC:0] sin_lut(input logic [LUT_BITS+1:0] p);
    logic [LUT_BITS:0]   idx;
    logic [COEF_W-1:0]   mag;
    idx = p[LUT_BITS] ? (LUT_BITS+1)'(QTR) - {1'b0, p[LUT_BITS-1:0]} : {1'b0, p[LUT_BITS-1:0]};
    mag = SIN_Q[idx];
    return p[LUT_BITS+1] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  logic                     adv, s1v, next_s1v;
  logic [NGRP-1:0][LO_W-1:0] lo_ph, next_lo;
  logic signed [OUT_W-1:0]  mi [NCH];
  logic signed [OUT_W-1:0]  mq [NCH];
  logic signed [OUT_W-1:0]  next_mi [NCH];
  logic signed [OUT_W-1:0]  next_mq [NCH];
  logic signed [ADC_W:0]    d;
  logic signed [2*ADC_W+1:0] pc, ps;
  logic signed [LO_FRAC:0]  cosv, nsinv;

  assign adv = clk_en & adc_valid & adc_ready & ~pdn;

  always_comb
  begin
    d        = '0;
    pc       = '0;
    ps       = '0;
    cosv     = '0;
    nsinv    = '0;
    next_lo  = lo_ph;
    next_s1v = s1v & ~pdn;
    next_mi  = mi;
    next_mq  = mq;
    if (adv)
    begin
      next_s1v = 1'b1;
      for (int g = 0; g < NGRP; g++)
        next_lo[g] = lo_ph[g] + freq[g];
      for (int c = 0; c < NCH; c++)
      begin
        cosv  = sin_lut(lo_ph[c/GRP][LO_W-1 -: LUT_BITS+2] + (LUT_BITS+2)'(QTR));
        nsinv = -sin_lut(lo_ph[c/GRP][LO_W-1 -: LUT_BITS+2]);
        d = {adc_in.smp[c][ADC_W-1], adc_in.smp[c]};
        if (!ctrl[B_DC_BYP])
          d = d - $signed({ofs[c/GRP][ADC_W-1], ofs[c/GRP]});
        pc = d * cosv;
        ps = d * nsinv;
        if (byp_all)
        begin
          next_mi[c] = OUT_W'($signed(adc_in.smp[c]));
          next_mq[c] = '0;
        end
        else if (ctrl[B_MIX_BYP])
        begin
          next_mi[c] = OUT_W'(d);
          next_mq[c] = '0;
        end
        else
        begin
          next_mi[c] = pc[LO_FRAC +: OUT_W];
          next_mq[c] = ps[LO_FRAC +: OUT_W];
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s1v   <= 1'b0;
      lo_ph <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        mi[c] <= '0;
        mq[c] <= '0;
      end
    end
    else if (clk_en)
    begin
      s1v   <= next_s1v;
      lo_ph <= next_lo;
      mi    <= next_mi;
      mq    <= next_mq;
    end
  end

  logic signed [ACC_W-1:0]   acc_i [NCH][TAPS_PER_M];
  logic signed [ACC_W-1:0]   acc_q [NCH][TAPS_PER_M];
  logic signed [ACC_W-1:0]   next_ai [NCH][TAPS_PER_M];
  logic signed [ACC_W-1:0]   next_aq [NCH][TAPS_PER_M];
  logic signed [ACC_W-1:0]   si [TAPS_PER_M];
  logic signed [ACC_W-1:0]   sq [TAPS_PER_M];
  logic signed [COEF_W-1:0]  h [NGRP][TAPS_PER_M];
  logic [KW-1:0]             k, half;
  logic                      last, emit;
  iqd_lane_s [NCH-1:0]       lanes;
  iqd_word_s                 wword;

  assign last = (MW'(ph) == decim - 1'b1);

  always_comb
  begin
    k       = '0;
    half    = KW'(BANK_PER_M) * KW'(decim);
    next_ph = ph;
    next_ai = acc_i;
    next_aq = acc_q;
    emit    = 1'b0;
    lanes   = '0;
    wword   = '0;
    si      = '{default: '0};
    sq      = '{default: '0};
    for (int g = 0; g < NGRP; g++)
      for (int j = 0; j < TAPS_PER_M; j++)
      begin
        // Tap distance from the block's last sample; mirrored half is symmetric.
        k = KW'(j) * KW'(decim) + KW'(decim) - KW'(1) - KW'(ph);
        if (k < half)
          h[g][j] = coef[g][CIW'(k)];
        else
          h[g][j] = coef[g][CIW'(half + half - KW'(1) - k)];
      end
    if (pdn || decim_wr)
    begin
      next_ph = '0;
      next_ai = '{default: '{default: '0}};
      next_aq = '{default: '{default: '0}};
    end
    else if (adv && s1v)
    begin
      if (byp_dec)
      begin
        emit = 1'b1;
        for (int c = 0; c < NCH; c++)
          lanes[c] = '{i: mi[c], q: mq[c]};
      end
      else
      begin
        emit    = last;
        next_ph = last ? '0 : ph + 1'b1;
        for (int c = 0; c < NCH; c++)
        begin
          for (int j = 0; j < TAPS_PER_M; j++)
          begin
            si[j] = acc_i[c][j] + ACC_W'(mi[c]) * ACC_W'(h[c/GRP][j]);
            sq[j] = acc_q[c][j] + ACC_W'(mq[c]) * ACC_W'(h[c/GRP][j]);
          end
          lanes[c] = '{i: si[0][COEF_FRAC +: OUT_W], q: sq[0][COEF_FRAC +: OUT_W]};
          for (int j = 0; j < TAPS_PER_M; j++)
          begin
            next_ai[c][j] = si[j];
            next_aq[c][j] = sq[j];
            if (last)
            begin
              next_ai[c][j] = (j < TAPS_PER_M - 1) ? si[(j+1) % TAPS_PER_M] : '0;
              next_aq[c][j] = (j < TAPS_PER_M - 1) ? sq[(j+1) % TAPS_PER_M] : '0;
            end
          end
        end
      end
    end
    for (int l = 0; l < NCH; l++)
      wword.lane[l] = byp_mux ? lanes[l] : lanes[muxsel[SEL_W*l +: SEL_W]];
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ph    <= '0;
      acc_i <= '{default: '{default: '0}};
      acc_q <= '{default: '{default: '0}};
    end
    else if (clk_en)
    begin
      ph    <= next_ph;
      acc_i <= next_ai;
      acc_q <= next_aq;
    end
  end

  // Two-entry output buffer: head register plus one spare.
  iqd_word_s  sp_w, next_spw, next_ow;
  logic       next_ov, next_spv, next_rdy, push, pop;

  assign push = emit;
  assign pop  = out_valid & out_ready;

  always_comb
  begin
    next_ov  = out_valid;
    next_ow  = out_word;
    next_spv = sp_v;
    next_spw = sp_w;
    if (pop)
    begin
      next_ov  = sp_v;
      next_ow  = sp_w;
      next_spv = 1'b0;
    end
    if (push && !next_ov)
    begin
      next_ov = 1'b1;
      next_ow = wword;
    end
    else if (push)
    begin
      next_spv = 1'b1;
      next_spw = wword;
    end
    // Ready looks at the next control value so it is low from the first power-down cycle.
    next_rdy = ~next_ctrl[B_PDN] & ((2'(next_ov) + 2'(next_spv)) < 2'(FIFO_DEPTH));
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_word  <= '0;
      sp_v      <= 1'b0;
      sp_w      <= '0;
      adc_ready <= 1'b0;
    end
    else if (clk_en)
    begin
      out_valid <= next_ov;
      out_word  <= next_ow;
      sp_v      <= next_spv;
      sp_w      <= next_spw;
      adc_ready <= next_rdy;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_dec_keep_one: assert property (push && !byp_dec |-> last)
    else $error("decimated word emitted off the last phase");
  a_phase_range: assert property (MW'(ph) < decim)
    else $error("decimation phase beyond factor");
  a_pdn_silent: assert property (pdn |-> !push && !adc_ready)
    else $error("activity during power down");
  a_lo_advance: assert property (adv |=> lo_ph[1] == $past(lo_ph[1]) + $past(freq[1]))
    else $error("oscillator phase did not step by frequency word");
  a_raw_bypass: assert property (adv && byp_all |=>
    mi[5] == OUT_W'($signed($past(adc_in.smp[5]))) && mq[5] == '0)
    else $error("bypass did not pass raw sample");
  a_dc_offset: assert property (adv && !byp_all && !ctrl[B_DC_BYP] && ctrl[B_MIX_BYP] |=>
    mi[4] == OUT_W'($signed($past(adc_in.smp[4])) - $signed($past(ofs[1]))))
    else $error("offset not removed in second group");
  a_buf_room: assert property (adc_ready |-> !(out_valid && sp_v))
    else $error("ready raised with full buffer");
  a_coef_step: assert property (clk_en && coef_wr |=> caddr == $past(caddr) + 1'b1)
    else $error("coefficient address did not advance");
  a_ack_pulse: assert property (clk_en && wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack ##1 !wb_ack [*1])
    else $error("ack not a single cycle answer");

  c_dec_word:  cover property (push && !byp_dec);
  c_buf_full:  cover property (out_valid && sp_v);
  c_push_pop:  cover property (push && pop && sp_v);
  c_coef_load: cover property (clk_en && coef_wr);
endmodule // iqd_top

// ### sim/iqd_sink.sv
`timescale 1ns/1ps
module iqd_sink (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic hold,
  output logic      out_ready
);
  int seed = 12286;
  // The receiver stalls at random, and for as long as hold stands.
  always @(posedge clk_sys)
  begin
    out_ready <= !reset && !hold && (($random(seed) & 3) != 0);
  end
endmodule // iqd_sink

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import iqd_pkg::*;
  logic              clk_sys, reset, clk_en, adc_valid, adc_ready;
  logic              out_valid, out_ready, wb_ack, hold, dec_mode, chk_q;
  iqd_adc_s          adc_in;
  iqd_word_s         out_word, ew;
  iqd_wb_req_s       wb_req;
  logic [31:0]       wb_dat_r, rd;
  logic [CTRL_W-1:0] ctrl;
  logic [23:0]       mux;
  logic [13:0]       ofs [2];
  logic [5:0]        modes [3];
  iqd_word_s         exp_q [$];
  int                n_fail, samples_checked, seed, n_out;

  iqd_top #(.MAX_DECIM(4)) i_iqd_top (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .adc_in(adc_in),
    .adc_valid(adc_valid), .adc_ready(adc_ready), .out_valid(out_valid),
    .out_word(out_word), .out_ready(out_ready), .wb_req(wb_req), .wb_ack(wb_ack),
    .wb_dat_r(wb_dat_r));
  iqd_sink i_iqd_sink (.clk_sys(clk_sys), .reset(reset), .hold(hold), .out_ready(out_ready));

  initial
  begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Classic single cycle; the request stands until ack is sampled high.
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int t;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    t = 0;
    do
    begin
      @(posedge clk_sys);
      t++;
    end while (wb_ack !== 1'b1 && t < 50);
    rd = wb_dat_r;
    if (t >= 50)
    begin
      n_fail++;
      print_verdict();
    end
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rdchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    check(rd, exp);
  endtask

  function iqd_adc_s rnd();
    iqd_adc_s    s;
    logic [31:0] r;
    for (int c = 0; c < NCH; c++)
    begin
      r = $random(seed);
      s.smp[c] = {{2{r[11]}}, r[11:0]};
    end
    return s;
  endfunction

  function iqd_word_s expw(input iqd_adc_s s);
    iqd_word_s  w;
    logic [13:0] d;
    int          src;
    w = '0;
    for (int l = 0; l < NCH; l++)
    begin
      src = (ctrl[B_MUX_BYP] || ctrl[B_DEMOD_BYP]) ? l : int'(mux[3*l +: 3]);
      d = s.smp[src];
      if (!ctrl[B_DC_BYP] && !ctrl[B_DEMOD_BYP])
        d = d - ofs[src / GRP];
      w.lane[l].i = {{2{d[13]}}, d};
    end
    return w;
  endfunction

  // A sample counts only at an edge where adc_ready was high.
  task send(input int n);
    int k, t;
    k = 0;
    t = 0;
    adc_valid <= 1'b1;
    adc_in <= rnd();
    while (k < n && t < 2000)
    begin
      @(posedge clk_sys);
      t++;
      if (adc_ready === 1'b1)
      begin
        exp_q.push_back(expw(adc_in));
        k++;
        if (k < n)
          adc_in <= rnd();
      end
    end
    adc_valid <= 1'b0;
    if (t >= 2000)
    begin
      n_fail++;
      print_verdict();
    end
  endtask

  // Empties the buffer, then powers down, which also clears the held sample.
  task drain(input int left);
    int t, idle;
    t = 0;
    idle = 0;
    while (idle < 6 && t < 500)
    begin
      @(posedge clk_sys);
      t++;
      idle = out_valid ? 0 : idle + 1;
    end
    if (t >= 500)
    begin
      n_fail++;
      print_verdict();
    end
    check(exp_q.size(), left);
    wb(1'b1, A_CTRL, 32'h0000_0002);
    wb(1'b0, A_STAT, 32'h0000_0000);
    check(rd[0], 1'b1);
    check(adc_ready, 1'b0);
    exp_q.delete();
  endtask

  always @(posedge clk_sys)
  begin
    if (!reset && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      n_out++;
      if (!dec_mode && exp_q.size() == 0)
        check(1, 0);
      else if (!dec_mode)
      begin
        ew = exp_q.pop_front();
        for (int l = 0; l < NCH; l++)
        begin
          check(out_word.lane[l].i, ew.lane[l].i);
          if (chk_q)
            check(out_word.lane[l].q, 16'h0000);
        end
      end
    end
  end

  initial
  begin
    seed = 12286;
    n_fail = 0;
    samples_checked = 0;
    n_out = 0;
    clk_en = 1'b1;
    reset = 1'b1;
    adc_valid = 1'b0;
    adc_in = '0;
    wb_req = '0;
    hold = 1'b0;
    dec_mode = 1'b0;
    chk_q = 1'b1;
    ofs[0] = 14'h0155;
    ofs[1] = 14'h3E00;
    modes = '{6'h1C, 6'h38, 6'h18};
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rdchk(A_CTRL, 32'h0000_0000);
    rdchk(A_DECIM, 32'h0000_0001);
    rdchk(A_MUX, {8'h00, MUX_RST});
    rdchk(A_OFS1, 32'h0000_0000);
    rdchk(A_CADDR, 32'h0000_0000);
    rdchk(A_FREQ0, 32'h0000_0000);
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rdchk(8'h3C, 32'h0000_0000);
    wb(1'b1, A_FREQ1, 32'hFFFF_FFFF);
    rdchk(A_FREQ1, 32'h0000_FFFF);
    ctrl = 6'h01;
    wb(1'b1, A_CTRL, 32'(ctrl));
    hold <= 1'b1;
    fork
      send(40);
      begin
        repeat (15) @(posedge clk_sys);
        check(adc_ready, 1'b0);
        wb(1'b0, A_STAT, 32'h0000_0000);
        check(rd[10:9], 2'b10);
        hold <= 1'b0;
      end
    join
    drain(1);
    $display("test bypass and stall done");
    chk_q = 1'b0;
    for (int l = 0; l < NCH; l++)
      mux[3*l +: 3] = 3'(NCH - 1 - l);
    wb(1'b1, A_MUX, {8'h00, mux});
    wb(1'b1, A_OFS0, 32'(ofs[0]));
    wb(1'b1, A_OFS1, 32'(ofs[1]));
    rdchk(A_OFS0, 32'h0000_0155);
    for (int m = 0; m < 3; m++)
    begin
      ctrl = modes[m];
      wb(1'b1, A_CTRL, 32'(ctrl));
      send(30);
      drain(1);
      $display("test stage mode %h done", ctrl);
    end
    for (int i = 0; i < 64; i++)
    begin
      if (i % 32 == 0)
        wb(1'b1, A_CADDR, (i == 0) ? 32'h0000_0000 : 32'h0000_0020);
      wb(1'b1, A_CDATA, 32'(i * 37 + 5));
    end
    rdchk(A_CADDR, 32'h0000_0000);
    wb(1'b1, A_CADDR, 32'h0000_0020);
    rdchk(A_CDATA, 32'(32 * 37 + 5));
    $display("test coefficient bank done");
    ctrl = 6'h2C;
    wb(1'b1, A_CTRL, 32'(ctrl));
    wb(1'b1, A_DECIM, 32'h0000_0004);
    wb(1'b1, A_DECIM, 32'h0000_0000);
    wb(1'b1, A_DECIM, 32'h0000_0005);
    rdchk(A_DECIM, 32'h0000_0004);
    dec_mode = 1'b1;
    n_out = 0;
    send(33);
    drain(33);
    check(n_out, 8);
    $display("test decimation done");
    print_verdict();
  end
endmodule // tb_top
